// ==== core/evp_ctrl.sv ====
// Exception arbitration, automatic stacking, vector fetch and tail-chaining
module evp_ctrl
   import evp_pkg::*;
#(
   parameter int PRI_BITS = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // System exception sources (levels, held until taken)
   input wire logic nmi_req,
   input wire logic hard_fault_req,
   input wire logic mem_fault_req,
   input wire logic prefetch_fault_req,
   input wire logic data_fault_req,
   input wire logic undef_instr_req,
   input wire logic illegal_state_req,
   input wire logic svc_instr_req,
   input wire logic pendable_service_req,
   input wire logic debug_mon_req,
   input wire logic tick_req,
   // Peripheral sources
   input wire logic [EVP_NUM_IRQ-1:0] irq_raw,
   input wire logic low_voltage_detector_evt,
   input wire logic [3:0] dma_ch_req,
   input wire logic adc_req,
   input wire logic [1:0] analog_comparators_req,
   input wire logic [3:0] tmr_butc_req,
   input wire logic tmr_cc_req,
   // Programmable priorities, one field per vector
   input wire logic [EVP_NUM_VEC*PRI_BITS-1:0] prio_cfg,
   // Core handshake
   input wire logic handler_return,
   input wire logic [31:0] stack_ptr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output evp_mem_req_s mem_req,
   output evp_exc_s exc_out,
   output logic handler_mode,
   output logic [5:0] ack_vec,
   output logic ack_pulse
);
   // Sequencer states
   typedef enum logic [2:0] {EVP_IDLE, EVP_STACK, EVP_RUN, EVP_UNSTACK} evp_state_e;

   // Pending per vector
   logic [EVP_NUM_VEC-1:0] pend;
   logic [EVP_NUM_IRQ-1:0] irq_line;
   evp_state_e state_reg, state_next;
   logic [3:0] cnt_reg; // Stack word count
   logic [5:0] vec_reg; // Vector being served
   logic [31:0] handler_reg; // Fetched handler address
   logic fetched_reg; // Vector read complete
   logic [31:0] sp_reg; // Frame base
   logic [4:0] cur_pri_reg; // Running priority

   // Peripheral line combining
   always_comb begin
      irq_line = irq_raw;
      irq_line[EVP_IRQ_LOW_VOLT] = irq_raw[EVP_IRQ_LOW_VOLT]
                                   | low_voltage_detector_evt;
      irq_line[EVP_IRQ_DMA12] = irq_raw[EVP_IRQ_DMA12] | dma_ch_req[0] | dma_ch_req[1];
      irq_line[EVP_IRQ_DMA34] = irq_raw[EVP_IRQ_DMA34] | dma_ch_req[2] | dma_ch_req[3];
      irq_line[EVP_IRQ_ADC] = irq_raw[EVP_IRQ_ADC] | adc_req | (|analog_comparators_req);
      irq_line[EVP_IRQ_TMR_BUTC] = irq_raw[EVP_IRQ_TMR_BUTC] | (|tmr_butc_req);
      irq_line[EVP_IRQ_TMR_CC] = irq_raw[EVP_IRQ_TMR_CC] | tmr_cc_req;
   end

   // Pending vector map; reset vector is never requested after boot
   always_comb begin
      pend = '0;
      pend[EVP_VEC_NMI] = nmi_req;
      pend[EVP_VEC_HARD] = hard_fault_req;
      pend[EVP_VEC_MEM] = mem_fault_req;
      pend[EVP_VEC_BUS] = prefetch_fault_req | data_fault_req;
      pend[EVP_VEC_USAGE] = undef_instr_req | illegal_state_req;
      pend[EVP_VEC_SVC] = svc_instr_req;
      pend[EVP_VEC_DEBUG] = debug_mon_req;
      pend[EVP_VEC_PENDSVC] = pendable_service_req;
      pend[EVP_VEC_TICK] = tick_req;
      pend[EVP_NUM_VEC-1:EVP_IRQ_BASE] = irq_line;
   end

   // Effective priority of one vector
   function automatic logic [4:0] eff_pri(input int v);
      logic [4:0] p;
      p = EVP_PRI_PROG_BASE + 5'(prio_cfg[v*PRI_BITS +: PRI_BITS]);
      if (v == int'(EVP_VEC_RESET)) p = EVP_PRI_RESET;
      if (v == int'(EVP_VEC_NMI)) p = EVP_PRI_NMI;
      if (v == int'(EVP_VEC_HARD)) p = EVP_PRI_HARD;
      return p;
   endfunction

   // Priority search: lowest value wins, lowest vector breaks ties
   logic [4:0] best_pri;
   logic [5:0] best_vec;
   logic best_ok;
   always_comb begin
      best_pri = EVP_PRI_IDLE;
      best_vec = '0;
      best_ok = 1'b0;
      for (int v = EVP_NUM_VEC-1; v >= 0; v--) begin
         if (pend[v] && eff_pri(v) <= best_pri) begin
            best_pri = eff_pri(v);
            best_vec = 6'(v);
            best_ok = 1'b1;
         end
      end
   end

   // Pre-emption only when strictly more urgent than what runs
   // Only idle is ever pre-empted here: a running handler is never nested
   wire take_new = best_ok && (best_pri < cur_pri_reg);
   // At return, anything pending chains straight in
   wire chain = handler_return && best_ok;
   wire stack_done = (cnt_reg == EVP_FRAME_WORDS) && fetched_reg;
   // Table word of the vector being served: four bytes per entry
   wire [31:0] cur_vec_addr = EVP_TABLE_BASE + (32'(vec_reg) << EVP_TABLE_SHIFT);

   // Next-state decode
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         EVP_IDLE: if (take_new) state_next = EVP_STACK;
         EVP_STACK: if (stack_done) state_next = EVP_RUN;
         EVP_RUN: begin
            // Chained entry refetches the vector only; frame stays
            if (chain) state_next = EVP_STACK;
            else if (handler_return) state_next = EVP_UNSTACK;
         end
         EVP_UNSTACK: if (cnt_reg == EVP_FRAME_WORDS) state_next = EVP_IDLE;
         default: state_next = EVP_IDLE;
      endcase
   end

   // Memory port: stack writes, table read slotted among them, unstack reads
   // Table read sits at the first odd count of a fresh frame; a chained entry starts
   // with the frame already counted full, so the read is then its only transfer
   wire frame_full = (cnt_reg == EVP_FRAME_WORDS);
   wire fetch_turn = cnt_reg[0] || frame_full;
   wire fetch_slot = (state_reg == EVP_STACK) && !fetched_reg && fetch_turn;
   wire stack_wr = (state_reg == EVP_STACK) && !fetch_slot && (cnt_reg != EVP_FRAME_WORDS);
   always_comb begin
      mem_req.valid = stack_wr || fetch_slot || (state_reg == EVP_UNSTACK
                      && cnt_reg != EVP_FRAME_WORDS);
      mem_req.write = stack_wr;
      if (fetch_slot) mem_req.addr = cur_vec_addr;
      else mem_req.addr = sp_reg + {26'h0, cnt_reg, 2'b00};
   end

   // Sequencer registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= EVP_IDLE;
         cnt_reg <= '0;
         vec_reg <= '0;
         fetched_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // A chain keeps the stacked frame, so it enters with the count full: no restack
         if (state_reg == EVP_RUN && chain) cnt_reg <= EVP_FRAME_WORDS;
         else if (state_reg != state_next) cnt_reg <= '0;
         else if (mem_ack && mem_req.valid && !fetch_slot) cnt_reg <= cnt_reg + 4'h1;
         // Latch winner at entry or chain
         if ((state_reg == EVP_IDLE && take_new) || (state_reg == EVP_RUN && chain)) begin
            vec_reg <= best_vec;
            fetched_reg <= 1'b0;
         end else if (fetch_slot && mem_ack) begin
            fetched_reg <= 1'b1;
         end
      end
   end

   // Frame base, handler address and running priority
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sp_reg <= '0;
         handler_reg <= '0;
         cur_pri_reg <= EVP_PRI_IDLE;
      end else begin
         // Frame grows down by eight words; reused across a chain
         if (state_reg == EVP_IDLE && take_new) begin
            sp_reg <= stack_ptr - {26'h0, EVP_FRAME_WORDS, 2'b00};
            cur_pri_reg <= best_pri;
         end
         if (state_reg == EVP_RUN && chain) cur_pri_reg <= best_pri;
         if (fetch_slot && mem_ack) handler_reg <= mem_rdata;
         if (state_reg == EVP_UNSTACK && state_next == EVP_IDLE) cur_pri_reg <= EVP_PRI_IDLE;
      end
   end

   // Delivery outputs
   logic ack_reg;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ack_reg <= 1'b0;
         exc_out <= '0;
      end else begin
         // Entry pulse lands with the first handler-state cycle, so the core sees both at once
         ack_reg <= (state_reg == EVP_STACK) && stack_done;
         exc_out.active <= (state_next == EVP_RUN);
         exc_out.vec <= vec_reg;
         exc_out.handler <= handler_reg;
      end
   end

   assign handler_mode = exc_out.active;
   assign ack_pulse = ack_reg;
   assign ack_vec = exc_out.vec;
endmodule

// ==== core/evp_pkg.sv ====
// Package: vector numbers, table offsets, priorities and carriers for the exception vectoring block
package evp_pkg;
   // Vector numbers of system exceptions
   localparam logic [5:0] EVP_VEC_RESET = 6'h01;
   localparam logic [5:0] EVP_VEC_NMI = 6'h02;
   localparam logic [5:0] EVP_VEC_HARD = 6'h03;
   localparam logic [5:0] EVP_VEC_MEM = 6'h04;
   localparam logic [5:0] EVP_VEC_BUS = 6'h05;
   localparam logic [5:0] EVP_VEC_USAGE = 6'h06;
   localparam logic [5:0] EVP_VEC_SVC = 6'h0b;
   localparam logic [5:0] EVP_VEC_DEBUG = 6'h0c;
   localparam logic [5:0] EVP_VEC_PENDSVC = 6'h0e;
   localparam logic [5:0] EVP_VEC_TICK = 6'h0f;
   // Peripheral lines start at this vector
   localparam logic [5:0] EVP_IRQ_BASE = 6'h10;
   localparam int EVP_NUM_IRQ = 17;
   localparam int EVP_NUM_VEC = 33;
   // Peripheral line indices with combined sources
   localparam int EVP_IRQ_LOW_VOLT = 1;
   localparam int EVP_IRQ_DMA12 = 10;
   localparam int EVP_IRQ_DMA34 = 11;
   localparam int EVP_IRQ_ADC = 12;
   localparam int EVP_IRQ_TMR_BUTC = 13;
   localparam int EVP_IRQ_TMR_CC = 14;
   // Handler table: word address is vector shifted left by this amount
   localparam int EVP_TABLE_SHIFT = 2;
   localparam logic [31:0] EVP_TABLE_BASE = 32'h0000_0000;
   // Priority encoding: 5 bits, fixed levels sort below all programmable ones
   localparam logic [4:0] EVP_PRI_RESET = 5'h00; // -3
   localparam logic [4:0] EVP_PRI_NMI = 5'h01; // -2
   localparam logic [4:0] EVP_PRI_HARD = 5'h02; // -1
   localparam logic [4:0] EVP_PRI_PROG_BASE = 5'h03; // programmable level 0
   localparam logic [4:0] EVP_PRI_IDLE = 5'h1f; // thread level
   // Words stacked on entry
   localparam logic [3:0] EVP_FRAME_WORDS = 4'h8;

   // Stack bus request towards the core's memory port
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } evp_mem_req_s;

   // Delivery to the core
   typedef struct packed {
      logic active;
      logic [5:0] vec;
      logic [31:0] handler;
   } evp_exc_s;
endpackage

// ==== test/evp_core_model.sv ====
// Core-side memory partner: acks stack and table traffic, promptly or slowly
module evp_core_model
   import evp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Two idle cycles before the first ack of a back-to-back run when high, one before each later ack
   input wire logic slow,
   // Memory port
   input wire evp_mem_req_s mem_req,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_cnt;
   wire logic go = mem_req.valid && !mem_ack && wait_cnt >= (slow ? 2'h2 : 2'h0);
   // Registered ack; data toggles outside acks so stale values never look valid
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mem_ack <= 1'b0;
         wait_cnt <= 2'h0;
         mem_rdata <= 32'h0;
      end else begin
         mem_ack <= go;
         wait_cnt <= (go || !mem_req.valid) ? 2'h0 : wait_cnt + 2'h1;
         // Table words hold 0x8000_0000 plus their own offset
         mem_rdata <= !go ? ~mem_rdata : mem_req.addr < 32'h100 ?
            32'h8000_0000 | mem_req.addr : ~mem_req.addr;
      end
   end
endmodule

// ==== test/evp_ctrl_properties.sv ====
// Checker: timing relations at the exception block's ports
module evp_ctrl_properties
   import evp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Watched ports
   input wire logic mem_ack,
   input wire logic handler_return,
   input wire evp_mem_req_s mem_req,
   input wire evp_exc_s exc_out,
   input wire logic handler_mode,
   input wire logic [5:0] ack_vec,
   input wire logic ack_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_mode_tracks: assert property (
      handler_mode == exc_out.active && ack_vec == exc_out.vec)
      else $error("mode or vector port differs from delivery");
   a_pulse_single: assert property (ack_pulse |=> !ack_pulse)
      else $error("entry pulse longer than one cycle");
   a_entry_marks: assert property ($rose(exc_out.active) |-> ack_pulse)
      else $error("handler state entered without entry pulse");
   a_held_active: assert property (exc_out.active && !handler_return |=>
      exc_out.active && $stable(exc_out.vec)) else $error("running handler lost");
   a_req_holds: assert property (mem_req.valid && !mem_ack |=>
      mem_req.valid && $stable(mem_req)) else $error("memory request changed before ack");
   a_word_align: assert property (mem_req.valid |-> mem_req.addr[1:0] == 2'h0)
      else $error("memory address not word aligned");
   a_entry_time: assert property ($rose(mem_req.valid) && mem_req.write |->
      ##[1:100] ack_pulse) else $error("entry did not complete in time");
   a_no_restack: assert property (
      exc_out.active |-> !(mem_req.valid && mem_req.write))
      else $error("stack write while a handler is active");
   // A return either refetches a vector or unstacks: both begin with a read
   a_return_reads: assert property (
      handler_mode && handler_return |=> mem_req.valid && !mem_req.write)
      else $error("no read request right after a handler return");
   // No write may follow a return soon: a chain reuses the frame, an unstack reads 8 words
   a_chain_nowrite: assert property (
      handler_mode && handler_return |=> (!(mem_req.valid && mem_req.write)) [*8])
      else $error("stack write right after a handler return");
endmodule

bind evp_ctrl evp_ctrl_properties evp_ctrl_properties_i (.mclk(mclk), .nrst(nrst),
   .mem_ack(mem_ack), .handler_return(handler_return), .mem_req(mem_req),
   .exc_out(exc_out), .handler_mode(handler_mode), .ack_vec(ack_vec), .ack_pulse(ack_pulse));

// ==== test/test_exception_vector_priority.sv ====
// Bench: drives exception sources, compares with a behavioural model
module test_exception_vector_priority
   import evp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, nrst = 0, slow = 0, handler_return = 0;
   logic [40:0] src = '0; // 11 system sources, 17 lines, combined sources
   logic [131:0] prio_cfg = '0;
   logic [31:0] stack_ptr = 32'h2000_0800, mem_rdata, ta, wa;
   logic mem_ack, handler_mode, ack_pulse;
   logic [5:0] ack_vec;
   evp_mem_req_s mem_req;
   evp_exc_s exc_out;
   int n_errors = 0, checks = 0, nw = 0, nr = 0;
   evp_ctrl evp_ctrl_i (.mclk(mclk), .nrst(nrst), .nmi_req(src[0]), .hard_fault_req(src[1]),
      .mem_fault_req(src[2]), .prefetch_fault_req(src[3]), .data_fault_req(src[4]),
      .undef_instr_req(src[5]), .illegal_state_req(src[6]), .svc_instr_req(src[7]),
      .pendable_service_req(src[8]), .debug_mon_req(src[9]), .tick_req(src[10]),
      .irq_raw(src[27:11]), .low_voltage_detector_evt(src[28]), .dma_ch_req(src[32:29]),
      .adc_req(src[33]), .analog_comparators_req(src[35:34]), .tmr_butc_req(src[39:36]),
      .tmr_cc_req(src[40]), .prio_cfg(prio_cfg), .handler_return(handler_return),
      .stack_ptr(stack_ptr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
      .exc_out(exc_out), .handler_mode(handler_mode), .ack_vec(ack_vec), .ack_pulse(ack_pulse));
   evp_core_model evp_core_model_i (.mclk(mclk), .nrst(nrst), .slow(slow), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   initial forever #50 mclk = ~mclk;
   // Count completed transfers; table reads sit below the stack region
   always @(posedge mclk) if (mem_req.valid && mem_ack) begin
      if (mem_req.write) begin nw++; wa = mem_req.addr; end
      else begin nr++; if (mem_req.addr < 32'h100) ta = mem_req.addr; end
   end
   // Vector of each source bit
   function automatic int vmap(int i);
      int t[11] = '{2, 3, 4, 5, 5, 6, 6, 11, 14, 12, 15};
      if (i < 11) return t[i];
      if (i < 28) return i + 5;
      if (i == 28) return 17;
      if (i < 33) return i < 31 ? 26 : 27;
      return i < 36 ? 28 : i < 40 ? 29 : 30;
   endfunction
   // Winner: lowest priority value, then lowest vector; 0 when nothing pends
   function automatic int win();
      int b = 0, bp = 99, v, p;
      for (int i = 0; i < 41; i++) if (src[i]) begin
         v = vmap(i);
         p = v < 4 ? v - 1 : prio_cfg[v*4+:4] + 3;
         if (p < bp || (p == bp && v < b)) begin b = v; bp = p; end
      end
      return b;
   endfunction
   task automatic chk(string what, logic [31:0] e, logic [31:0] s);
      checks++;
      if (e !== s) begin n_errors++; $display("unexpected %s expected %h seen %h", what, e, s); end
   endtask
   // Wait for entry, compare with the model, drop the served sources
   task automatic take(int w);
      int v = win(), k = 0;
      while (ack_pulse !== 1'b1 && k < 500) begin
         @(negedge mclk);
         k++;
      end
      // A wait that runs out shows up here as a missing entry pulse
      chk("entry pulse", 1, ack_pulse);
      chk("vector", v, exc_out.vec);
      chk("ack vector", v, ack_vec);
      chk("handler mode", 1, handler_mode);
      chk("writes", w, nw);
      chk("reads", 1, nr);
      chk("table", v * 4, ta);
      chk("handler", 32'h8000_0000 | v * 4, exc_out.handler);
      if (w > 0) chk("frame top", stack_ptr - 4, wa);
      for (int i = 0; i < 41; i++) if (vmap(i) == v) src[i] = 0;
   endtask
   task automatic ret();
      nw = 0; nr = 0; ta = '1;
      @(negedge mclk);
      handler_return = 1;
      @(negedge mclk);
      handler_return = 0;
   endtask
   task automatic run(int a, int b);
      slow = 1'($urandom);
      stack_ptr = 32'h2000_0800 + 32'($urandom_range(255) * 4);
      src[a] = 1;
      src[b] = 1;
      take(8);
      ret();
      // A second pending source is taken by a chain: no writes, one table read
      if (win() != 0) begin
         take(0);
         ret();
      end
      repeat (60) @(negedge mclk);
      chk("unstack reads", 8, nr);
      chk("unstack writes", 0, nw);
      chk("mode after return", 0, handler_mode);
      nw = 0;
      nr = 0;
      ta = '1;
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin #(60000 * 100); n_errors++; stop_test(); end
   initial begin
      void'($urandom(78));
      repeat (4) @(negedge mclk);
      chk("reset outputs", 0, {mem_req.valid, exc_out.active, ack_pulse});
      nrst = 1;
      @(negedge mclk);
      for (int i = 0; i < 28; i++) run(i, i);
      for (int i = 28; i < 41; i++) run(i, i);
      run(0, 11);
      run(1, 8);
      // Reset in the middle of stacking: outputs drop at once, the next entry starts clean
      src[20] = 1;
      repeat (6) @(negedge mclk);
      nrst = 0;
      src[20] = 0;
      repeat (4) @(negedge mclk);
      chk("mid-run reset outputs", 0, {mem_req.valid, exc_out.active, ack_pulse, handler_mode});
      nrst = 1;
      nw = 0;
      nr = 0;
      ta = '1;
      @(negedge mclk);
      for (int k = 0; k < 24; k++) begin
         for (int f = 0; f < 33; f++) prio_cfg[f*4+:4] = 4'($urandom);
         run($urandom_range(40), $urandom_range(40));
      end
      stop_test();
   end
endmodule
